//--- clock_gen_regs.vh
/*
 * constants for the clock generator start-up control: timing figures,
 * stabilization-time codes, reset values and clock source codes.
 * assumes a single 200 MHz core clock and inclusion by bare name.
 */
`ifndef CLOCK_GEN_REGS_VH
`define CLOCK_GEN_REGS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define POR_RISE_WINDOW_NS 1930000
`define POR_STAB_DELAY_NS 5390000

// ----------------------------------------------------------------------
// stabilization time select codes and reset values
// ----------------------------------------------------------------------
`define STAB_SEL_RESET 3'h5
`define STAB_STATUS_RESET 5'h00
`define STAB_CODE_2P11 3'h1
`define STAB_CODE_2P13 3'h2
`define STAB_CODE_2P14 3'h3
`define STAB_CODE_2P15 3'h4
`define STAB_CODE_2P16 3'h5
`define STAB_LIM_2P11 17'h00800
`define STAB_LIM_2P13 17'h02000
`define STAB_LIM_2P14 17'h04000
`define STAB_LIM_2P15 17'h08000
`define STAB_LIM_2P16 17'h10000

// ----------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------
`define STAB_BIT_2P11 4
`define STAB_BIT_2P13 3
`define STAB_BIT_2P14 2
`define STAB_BIT_2P15 1
`define STAB_BIT_2P16 0

// ----------------------------------------------------------------------
// processor clock sources and prescaler select limit
// ----------------------------------------------------------------------
`define CPU_SRC_INT_HS 2'h0
`define CPU_SRC_MAIN 2'h1
`define CPU_SRC_SUB 2'h2
`define PRESC_MAX_SEL 3'h4

`endif

//--- stab_counter.v
/*
 * oscillation stabilization counter and its status bits.
 * assumes xtalTick is a one-cycle pulse per crystal cycle, synchronous to core_clk.
 */
module stab_counter (
    core_clk,
    rstn,
    clearReq,
    counting,
    xtalTick,
    selCode,
    stabStatus,
    stabDone
);
`include "clock_gen_regs.vh"
    input wire core_clk;
    input wire rstn;
    input wire clearReq;
    input wire counting;
    input wire xtalTick;
    input wire [2:0] selCode;
    output reg [4:0] stabStatus;
    output wire stabDone;

    reg [16:0] count_q;

    // ------------------------------------------------------------------
    // wait length for a select code; prohibited codes fall to the longest
    // ------------------------------------------------------------------
    function [16:0] limitOf;
        input [2:0] code;
        begin
            case (code)
                `STAB_CODE_2P11: limitOf = `STAB_LIM_2P11;
                `STAB_CODE_2P13: limitOf = `STAB_LIM_2P13;
                `STAB_CODE_2P14: limitOf = `STAB_LIM_2P14;
                `STAB_CODE_2P15: limitOf = `STAB_LIM_2P15;
                default: limitOf = `STAB_LIM_2P16;
            endcase
        end
    endfunction

    wire [16:0] limit = limitOf(selCode);
    assign stabDone = (count_q >= limit);

    // ------------------------------------------------------------------
    // counter and sticky status
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= 17'h00000;
            stabStatus <= `STAB_STATUS_RESET;
        end else if (clearReq) begin
            count_q <= 17'h00000;
            stabStatus <= `STAB_STATUS_RESET;
        end else begin
            if (counting && xtalTick && !stabDone) begin
                count_q <= count_q + 17'h00001;
            end
            // bits set in order and stay set; only up to the selected wait
            if (count_q >= `STAB_LIM_2P11 && limit >= `STAB_LIM_2P11) begin
                stabStatus[`STAB_BIT_2P11] <= 1'b1;
            end
            if (count_q >= `STAB_LIM_2P13 && limit >= `STAB_LIM_2P13) begin
                stabStatus[`STAB_BIT_2P13] <= 1'b1;
            end
            if (count_q >= `STAB_LIM_2P14 && limit >= `STAB_LIM_2P14) begin
                stabStatus[`STAB_BIT_2P14] <= 1'b1;
            end
            if (count_q >= `STAB_LIM_2P15 && limit >= `STAB_LIM_2P15) begin
                stabStatus[`STAB_BIT_2P15] <= 1'b1;
            end
            if (count_q >= `STAB_LIM_2P16 && limit >= `STAB_LIM_2P16) begin
                stabStatus[`STAB_BIT_2P16] <= 1'b1;
            end
        end
    end

endmodule

//--- clock_gen_ctrl.v
/*
 * clock generator start-up and source control: power-on release sequence,
 * oscillator enables, processor clock source, prescaler, subsystem pin
 * port fallback and the stabilization-time select / status bits.
 * assumes all inputs synchronous to core_clk; crystal cycles arrive as
 * one-cycle tick pulses; the analogue oscillators obey the enables.
 */
`include "clock_gen_regs.vh"
// Overview of operation
// - subsystem pins become I/O when select is 0
// - direction bit 1 means input, 0 output
// - internal high-speed oscillator starts at reset release
// - software can start and stop internal high-speed
// - low-speed clock feeds watchdog, timer only
// - option decides if low-speed is stoppable
// - low-speed starts at release, watchdog runs
// - prescaler divides main clock while CPU uses it
// - provide main, sub, low-speed, CPU, peripheral clocks
// - CPU starts on internal high-speed, no wait
// - release reset once supply above low threshold
// - status check, or device wait on crystal
// - external clock input needs no stabilization wait
// - dual mode inserts delay before reset processing when high threshold is reached within the rise window
// - option selects single or dual threshold mode
// - non-CPU clocks stoppable; stop halts high-speed
// - select resets to 05H, codes 001..101
// - status cleared, then bits set in order
module clock_gen_ctrl #(
    parameter integer RISE_WINDOW_CYC = `POR_RISE_WINDOW_NS / `CLK_PERIOD_NS,
    parameter integer STAB_DELAY_CYC = (`POR_STAB_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter integer CNT_W = 21
) (
    core_clk,
    rstn,
    supplyAboveLow,
    supplyAboveHigh,
    powerOnModeOption,
    lowSpeedStopAllowed,
    intHsStopReq,
    intLsStopReq,
    mainOscStopReq,
    mainExtClkSel,
    subOscStopReq,
    subExtClkSel,
    stopInsn,
    stopRelease,
    cpuSrcReq,
    prescSel,
    stabTimeWrite,
    stabTimeWdata,
    mainXtalTick,
    subOscSelect,
    subPin1Direction,
    subPin2Direction,
    subPin1OutVal,
    subPin2OutVal,
    subPin1In,
    subPin2In,
    coreRstn,
    cpuRun,
    intHsRun,
    intLsRun,
    wdtClkEn,
    timerH1ClkEn,
    mainOscEnable,
    subOscEnable,
    mainClkReady,
    cpuClkSrc,
    periphClkHs,
    cpuClkTick,
    prescTaps,
    stabTimeSel,
    stabStatus,
    subPin1Out,
    subPin1Oe_n,
    subPin2Out,
    subPin2Oe_n,
    subPin1Read,
    subPin2Read
);
    input wire core_clk;
    input wire rstn;
    input wire supplyAboveLow;
    input wire supplyAboveHigh;
    input wire powerOnModeOption;
    input wire lowSpeedStopAllowed;
    input wire intHsStopReq;
    input wire intLsStopReq;
    input wire mainOscStopReq;
    input wire mainExtClkSel;
    input wire subOscStopReq;
    input wire subExtClkSel;
    input wire stopInsn;
    input wire stopRelease;
    input wire [1:0] cpuSrcReq;
    input wire [2:0] prescSel;
    input wire stabTimeWrite;
    input wire [2:0] stabTimeWdata;
    input wire mainXtalTick;
    input wire subOscSelect;
    input wire subPin1Direction;
    input wire subPin2Direction;
    input wire subPin1OutVal;
    input wire subPin2OutVal;
    input wire subPin1In;
    input wire subPin2In;
    output reg coreRstn;
    output wire cpuRun;
    output reg intHsRun;
    output reg intLsRun;
    output wire wdtClkEn;
    output wire timerH1ClkEn;
    output reg mainOscEnable;
    output reg subOscEnable;
    output wire mainClkReady;
    output reg [1:0] cpuClkSrc;
    output reg periphClkHs;
    output reg cpuClkTick;
    output reg [3:0] prescTaps;
    output reg [2:0] stabTimeSel;
    output wire [4:0] stabStatus;
    output reg subPin1Out;
    output reg subPin1Oe_n;
    output reg subPin2Out;
    output reg subPin2Oe_n;
    output reg subPin1Read;
    output reg subPin2Read;

    // ------------------------------------------------------------------
    // power-on sequencer
    // ------------------------------------------------------------------
    localparam [1:0] ST_OFF = 2'h0;
    localparam [1:0] ST_RISE = 2'h1;
    localparam [1:0] ST_DELAY = 2'h2;
    localparam [1:0] ST_RUN = 2'h3;
    localparam [CNT_W-1:0] RISE_LIM = RISE_WINDOW_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] DELAY_LIM = STAB_DELAY_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    reg [1:0] porState_q;
    reg [1:0] porState_d;
    reg [CNT_W-1:0] porCnt_q;
    reg [CNT_W-1:0] porCnt_d;
    reg lsStoppable_q;

    always @* begin
        porState_d = porState_q;
        porCnt_d = porCnt_q;
        case (porState_q)
            ST_OFF: begin
                porCnt_d = {CNT_W{1'b0}};
                if (supplyAboveLow) begin
                    // single threshold: release straight away
                    porState_d = powerOnModeOption ? ST_RISE : ST_RUN;
                end
            end
            ST_RISE: begin
                porCnt_d = porCnt_q + CNT_ONE;
                if (supplyAboveHigh) begin
                    porState_d = (porCnt_q < RISE_LIM) ? ST_DELAY : ST_RUN;
                end
            end
            ST_DELAY: begin
                // delay measured from the low-threshold crossing, so at most the full figure
                porCnt_d = porCnt_q + CNT_ONE;
                if (porCnt_q >= DELAY_LIM - CNT_ONE) begin
                    porState_d = ST_RUN;
                end
            end
            ST_RUN: begin
                porCnt_d = porCnt_q;
            end
            default: begin
                porState_d = ST_OFF;
            end
        endcase
        if (!supplyAboveLow) begin
            porState_d = ST_OFF;
        end
    end

    // option levels are sampled by the clock while held in reset, never by rstn itself
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            porState_q <= ST_OFF;
            porCnt_q <= {CNT_W{1'b0}};
            lsStoppable_q <= 1'b0;
            coreRstn <= 1'b0;
        end else begin
            porState_q <= porState_d;
            porCnt_q <= porCnt_d;
            if (porState_q == ST_OFF) begin
                lsStoppable_q <= lowSpeedStopAllowed;
            end
            coreRstn <= (porState_d == ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // stop mode and processor clock source
    // ------------------------------------------------------------------
    reg stopMode_q;
    reg cpuHold_q;
    wire stabDone;
    wire mainCrystal = !mainExtClkSel;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stopMode_q <= 1'b0;
            cpuHold_q <= 1'b0;
            cpuClkSrc <= `CPU_SRC_INT_HS;
            periphClkHs <= 1'b0;
        end else if (!coreRstn) begin
            stopMode_q <= 1'b0;
            cpuHold_q <= 1'b0;
            cpuClkSrc <= `CPU_SRC_INT_HS;
            periphClkHs <= 1'b0;
        end else begin
            if (stopInsn) begin
                stopMode_q <= 1'b1;
            end else if (stopRelease && stopMode_q) begin
                stopMode_q <= 1'b0;
                // on the crystal the device itself holds the CPU for the selected wait
                cpuHold_q <= (cpuClkSrc == `CPU_SRC_MAIN) && mainCrystal;
            end else if (cpuHold_q && stabDone) begin
                cpuHold_q <= 1'b0;
            end
            // low-speed code 3 is never accepted as the processor clock
            if (cpuSrcReq != 2'h3 && !stopMode_q) begin
                cpuClkSrc <= cpuSrcReq;
            end
            periphClkHs <= (cpuClkSrc == `CPU_SRC_MAIN) && mainOscEnable;
        end
    end

    assign cpuRun = coreRstn && !stopMode_q && !cpuHold_q;

    // ------------------------------------------------------------------
    // oscillator enables
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            intHsRun <= 1'b0;
            intLsRun <= 1'b0;
            mainOscEnable <= 1'b0;
            subOscEnable <= 1'b0;
        end else if (!coreRstn) begin
            intHsRun <= 1'b0;
            intLsRun <= 1'b0;
            mainOscEnable <= 1'b0;
            subOscEnable <= 1'b0;
        end else begin
            // a clock feeding the CPU ignores its stop request
            intHsRun <= !stopMode_q && !stopInsn &&
                        (!intHsStopReq || cpuClkSrc == `CPU_SRC_INT_HS);
            intLsRun <= lsStoppable_q ? !intLsStopReq : 1'b1;
            mainOscEnable <= !stopMode_q && !stopInsn &&
                             (!mainOscStopReq || cpuClkSrc == `CPU_SRC_MAIN);
            subOscEnable <= subOscSelect &&
                            (!subOscStopReq || cpuClkSrc == `CPU_SRC_SUB);
        end
    end

    assign wdtClkEn = intLsRun;
    assign timerH1ClkEn = intLsRun;

    // ------------------------------------------------------------------
    // stabilization time select and counter
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stabTimeSel <= `STAB_SEL_RESET;
        end else if (!coreRstn) begin
            stabTimeSel <= `STAB_SEL_RESET;
        end else if (stabTimeWrite) begin
            stabTimeSel <= stabTimeWdata;
        end
    end

    wire stabClear = !coreRstn || stopInsn || !mainOscEnable;

    stab_counter u_stab (
        .core_clk(core_clk),
        .rstn(rstn),
        .clearReq(stabClear),
        .counting(mainCrystal),
        .xtalTick(mainXtalTick),
        .selCode(stabTimeSel),
        .stabStatus(stabStatus),
        .stabDone(stabDone)
    );

    // external clock input is usable as soon as it is enabled
    assign mainClkReady = mainOscEnable && (mainExtClkSel || stabDone);

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    reg [4:0] presc_q;
    wire prescOn = coreRstn && !stopMode_q &&
                   (cpuClkSrc == `CPU_SRC_INT_HS || cpuClkSrc == `CPU_SRC_MAIN);

    // one-cycle tick at main clock / 2^sel; prohibited codes fall to the slowest
    function tapOf;
        input [4:0] cnt;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: tapOf = 1'b1;
                3'h1: tapOf = (cnt[0] == 1'b1);
                3'h2: tapOf = (cnt[1:0] == 2'h3);
                3'h3: tapOf = (cnt[2:0] == 3'h7);
                default: tapOf = (cnt[3:0] == 4'hf);
            endcase
        end
    endfunction

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            presc_q <= 5'h00;
            prescTaps <= 4'h0;
            cpuClkTick <= 1'b0;
        end else if (!prescOn) begin
            presc_q <= 5'h00;
            prescTaps <= 4'h0;
            cpuClkTick <= 1'b0;
        end else begin
            presc_q <= presc_q + 5'h01;
            prescTaps <= {tapOf(presc_q, 3'h4), tapOf(presc_q, 3'h3),
                          tapOf(presc_q, 3'h2), tapOf(presc_q, 3'h1)};
            cpuClkTick <= tapOf(presc_q, prescSel);
        end
    end

    // ------------------------------------------------------------------
    // subsystem pins: port mode unless the oscillator is selected
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            subPin1Out <= 1'b0;
            subPin1Oe_n <= 1'b1;
            subPin2Out <= 1'b0;
            subPin2Oe_n <= 1'b1;
            subPin1Read <= 1'b0;
            subPin2Read <= 1'b0;
        end else begin
            subPin1Out <= subOscSelect ? 1'b0 : subPin1OutVal;
            subPin2Out <= subOscSelect ? 1'b0 : subPin2OutVal;
            subPin1Oe_n <= subOscSelect || subPin1Direction;
            subPin2Oe_n <= subOscSelect || subPin2Direction;
            subPin1Read <= subOscSelect ? 1'b0 : subPin1In;
            subPin2Read <= subOscSelect ? 1'b0 : subPin2In;
        end
    end

endmodule

//--- clock_gen_ctrl_assertions.sv
/*
 * port-level checker for clock_gen_ctrl.
 * assumes one core_clk domain and rstn as its async active-low reset.
 */
module clock_gen_ctrl_assertions (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic coreRstn,
    input wire logic intHsRun,
    input wire logic intLsRun,
    input wire logic wdtClkEn,
    input wire logic timerH1ClkEn,
    input wire logic [1:0] cpuClkSrc,
    input wire logic [1:0] cpuSrcReq,
    input wire logic subOscSelect,
    input wire logic subPin1Direction,
    input wire logic subPin1OutVal,
    input wire logic subPin1In,
    input wire logic subPin1Out,
    input wire logic subPin1Oe_n,
    input wire logic subPin1Read,
    input wire logic stabTimeWrite,
    input wire logic [2:0] stabTimeWdata,
    input wire logic [2:0] stabTimeSel,
    input wire logic [4:0] stabStatus,
    input wire logic stopInsn,
    input wire logic mainOscEnable,
    input wire logic mainExtClkSel,
    input wire logic mainClkReady
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // --------------------
    // sequences
    // --------------------
    // inputs held two edges so the registered pin outputs have settled
    sequence portOut;
        coreRstn && !subOscSelect && !subPin1Direction;
    endsequence
    sequence portIn;
        coreRstn && !subOscSelect && subPin1Direction;
    endsequence
    // --------------------
    // assertions
    // --------------------
    a_ls_not_cpu: assert property (cpuClkSrc != 2'h3 && wdtClkEn == intLsRun
        && timerH1ClkEn == intLsRun) else $error("low-speed clock misused");
    a_osc_autostart: assert property ($rose(coreRstn) |=> intHsRun && intLsRun)
        else $error("oscillators not started after release");
    a_cpu_starts_hs: assert property ($rose(coreRstn) |-> cpuClkSrc == 2'h0
        ##1 cpuClkSrc == 2'h0) else $error("cpu not on internal clock at start");
    a_port_out: assert property (portOut ##1 portOut |-> !subPin1Oe_n
        && subPin1Out == $past(subPin1OutVal)) else $error("port output wrong");
    a_port_in: assert property (portIn ##1 portIn |-> subPin1Oe_n
        && subPin1Read == $past(subPin1In)) else $error("port input wrong");
    a_sel_write: assert property (coreRstn && stabTimeWrite |=>
        stabTimeSel == $past(stabTimeWdata)) else $error("select write lost");
    a_reset_vals: assert property (!coreRstn ##1 !coreRstn |-> stabTimeSel == 3'h5
        && stabStatus == 5'h00) else $error("reset values wrong");
    a_stab_order: assert property (stabStatus inside {5'h00, 5'h10, 5'h18,
        5'h1c, 5'h1e, 5'h1f}) else $error("status bits out of order");
    a_stop_halts: assert property (coreRstn && stopInsn |=> !intHsRun
        && !mainOscEnable && stabStatus == 5'h00) else $error("stop did not halt");
    a_ext_no_wait: assert property (mainOscEnable && mainExtClkSel |-> mainClkReady)
        else $error("external clock not ready");
    a_src_refused: assert property (coreRstn && cpuSrcReq == 2'h3 |=>
        $stable(cpuClkSrc)) else $error("source code 3 taken");
endmodule

bind clock_gen_ctrl clock_gen_ctrl_assertions chk_u (.core_clk, .rstn, .coreRstn, .intHsRun,
    .intLsRun, .wdtClkEn, .timerH1ClkEn, .cpuClkSrc, .cpuSrcReq, .subOscSelect,
    .subPin1Direction, .subPin1OutVal, .subPin1In, .subPin1Out, .subPin1Oe_n, .subPin1Read,
    .stabTimeWrite, .stabTimeWdata, .stabTimeSel, .stabStatus, .stopInsn, .mainOscEnable,
    .mainExtClkSel, .mainClkReady);

//--- clock_gen_ctrl_tb.sv
/*
 * self-checking bench for clock_gen_ctrl.
 * assumes clock_gen_regs.vh on the include path; short power-on counts.
 */
`include "clock_gen_regs.vh"
module clock_gen_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RISE = 20;
    localparam int DLY = 50;
    logic core_clk = 0, rstn = 0, supplyAboveLow = 0, supplyAboveHigh = 0;
    logic powerOnModeOption = 0, lowSpeedStopAllowed = 0, intHsStopReq = 0, intLsStopReq = 0;
    logic mainOscStopReq = 1, mainExtClkSel = 1, subOscStopReq = 1, stopInsn = 0;
    logic stopRelease = 0, stabTimeWrite = 0, mainXtalTick = 0, subOscSelect = 0;
    logic subPin1Direction = 1, subPin2Direction = 1, subPin1OutVal = 0, subPin2OutVal = 0;
    logic subPin1In = 0, subPin2In = 0;
    logic [1:0] cpuSrcReq = 2'h0;
    logic [2:0] prescSel = 3'h0, stabTimeWdata = 3'h0;
    wire coreRstn, cpuRun, intHsRun, intLsRun, wdtClkEn, timerH1ClkEn, mainOscEnable;
    wire subOscEnable, mainClkReady, periphClkHs, cpuClkTick, subPin1Out, subPin1Oe_n;
    wire subPin2Out, subPin2Oe_n, subPin1Read, subPin2Read;
    wire [1:0] cpuClkSrc;
    wire [3:0] prescTaps;
    wire [2:0] stabTimeSel;
    wire [4:0] stabStatus;
    int fails = 0, cmp_count = 0, n, m;

    clock_gen_ctrl #(.RISE_WINDOW_CYC(RISE), .STAB_DELAY_CYC(DLY)) dut_u (
        .core_clk, .rstn, .supplyAboveLow, .supplyAboveHigh, .powerOnModeOption,
        .lowSpeedStopAllowed, .intHsStopReq, .intLsStopReq, .mainOscStopReq, .mainExtClkSel,
        .subOscStopReq, .subExtClkSel(1'b0), .stopInsn, .stopRelease, .cpuSrcReq, .prescSel,
        .stabTimeWrite, .stabTimeWdata, .mainXtalTick, .subOscSelect, .subPin1Direction,
        .subPin2Direction, .subPin1OutVal, .subPin2OutVal, .subPin1In, .subPin2In, .coreRstn,
        .cpuRun, .intHsRun, .intLsRun, .wdtClkEn, .timerH1ClkEn, .mainOscEnable, .subOscEnable,
        .mainClkReady, .cpuClkSrc, .periphClkHs, .cpuClkTick, .prescTaps, .stabTimeSel,
        .stabStatus, .subPin1Out, .subPin1Oe_n, .subPin2Out, .subPin2Oe_n, .subPin1Read,
        .subPin2Read);

    always #2.5 core_clk = ~core_clk;

    // --------------------
    // helpers
    // --------------------
    // inputs move on the falling edge, away from the sampling edge
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic check(input logic [4:0] seen, input logic [4:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic wr_sel(input logic [2:0] code);
        stabTimeWrite = 1;
        stabTimeWdata = code;
        cyc(1);
        stabTimeWrite = 0;
        cyc(1);
    endtask
    // n ends as the cycles from low crossing to core reset release
    task automatic power_up(input logic mode, input int hi);
        rstn = 0;
        supplyAboveLow = 0;
        supplyAboveHigh = 0;
        powerOnModeOption = mode;
        cyc(10);
        rstn = 1;
        cyc(2);
        supplyAboveLow = 1;
        n = 0;
        while (coreRstn !== 1'b1 && n < 200) begin
            if (n == hi) supplyAboveHigh = 1;
            cyc(1);
            n++;
        end
        cyc(2);
    endtask
    // --------------------
    // scenarios
    // --------------------
    task automatic t_power;
        power_up(1'b0, 0);
        check(n <= 3, 1, "single threshold release");
        check(intHsRun, 1, "int hs idle");
        check({wdtClkEn, timerH1ClkEn, intLsRun}, 3'h7, "low speed idle");
        check(cpuClkSrc, `CPU_SRC_INT_HS, "cpu source");
        check(stabTimeSel, `STAB_SEL_RESET, "select reset");
        check(stabStatus, `STAB_STATUS_RESET, "status reset");
        intLsStopReq = 1;
        intHsStopReq = 1;
        cyc(3);
        check({intLsRun, intHsRun}, 2'h3, "locked clock stopped");
        intLsStopReq = 0;
        intHsStopReq = 0;
        power_up(1'b1, 5);
        check(n >= DLY - 2 && n <= DLY + 4, 1, "fast rise delay");
        lowSpeedStopAllowed = 1;
        power_up(1'b1, RISE + 10);
        check(n >= RISE + 10 && n <= RISE + 15, 1, "slow rise release");
        intLsStopReq = 1;
        cyc(3);
        check(intLsRun, 0, "low speed kept");
        intLsStopReq = 0;
        cyc(3);
        check(intLsRun, 1, "low speed restart");
    endtask
    task automatic t_pins;
        for (int i = 0; i < 4; i++) begin
            subPin1Direction = i[0];
            subPin2Direction = ~i[0];
            subPin1OutVal = i[1];
            subPin2OutVal = ~i[1];
            subPin1In = ~i[1];
            subPin2In = i[1];
            cyc(2);
            check({subPin1Oe_n, subPin2Oe_n}, {i[0], ~i[0]}, "pin direction");
            check(i[0] ? {subPin1Read, subPin2Out} : {subPin2Read, subPin1Out},
                i[0] ? {~i[1], ~i[1]} : {i[1], i[1]}, "port data");
        end
        subOscSelect = 1;
        subOscStopReq = 0;
        cyc(2);
        check({subPin1Read, subPin2Read, subOscEnable}, 3'h1, "osc mode pins");
        cpuSrcReq = `CPU_SRC_SUB;
        subOscStopReq = 1;
        cyc(3);
        check({cpuClkSrc, subOscEnable}, 3'h5, "cpu clock stopped");
        cpuSrcReq = `CPU_SRC_INT_HS;
        cyc(3);
        check(subOscEnable, 0, "sub not stopped");
        subOscSelect = 0;
    endtask
    task automatic t_main;
        mainOscStopReq = 0;
        cyc(2);
        check(mainClkReady, 1, "external clock wait");
        cpuSrcReq = `CPU_SRC_MAIN;
        cyc(2);
        cpuSrcReq = 2'h3;
        cyc(2);
        check({cpuClkSrc, periphClkHs}, 3'h3, "cpu source main");
        intHsStopReq = 1;
        cyc(2);
        check(intHsRun, 0, "int hs stop");
        intHsStopReq = 0;
        cyc(2);
        check(intHsRun, 1, "int hs start");
        prescSel = 3'h2;
        cyc(4);
        n = 0;
        m = 0;
        repeat (48) begin
            cyc(1);
            n += cpuClkTick;
            m += prescTaps[3];
        end
        check(n == 12, 1, "divide by four");
        check(m == 3, 1, "divide by sixteen");
        cpuSrcReq = `CPU_SRC_INT_HS;
        mainOscStopReq = 1;
        cyc(3);
        check(mainOscEnable, 0, "main stop");
    endtask
    // crystal tick on every cycle, so wait lengths are counted in cycles
    task automatic t_xtal;
        mainExtClkSel = 0;
        mainXtalTick = 1;
        for (int c = 1; c <= 2; c++) begin
            wr_sel(c);
            check(stabTimeSel, c, "select write");
            mainOscStopReq = 0;
            cyc((c == 1 ? `STAB_LIM_2P11 : `STAB_LIM_2P13) - 8);
            check(stabStatus, c == 1 ? 5'h00 : 5'h10, "status early");
            check(mainClkReady, 0, "ready early");
            cyc(16);
            check(stabStatus, c == 1 ? 5'h10 : 5'h18, "status late");
            check(mainClkReady, 1, "ready late");
            if (c == 1) begin
                mainOscStopReq = 1;
                cyc(2);
                check(stabStatus, 5'h00, "status clear");
            end
        end
    endtask
    task automatic t_stop;
        wr_sel(`STAB_CODE_2P11);
        cpuSrcReq = `CPU_SRC_MAIN;
        cyc(2);
        stopInsn = 1;
        cyc(1);
        stopInsn = 0;
        cyc(1);
        check({intHsRun, mainOscEnable, cpuRun}, 3'h0, "stop mode");
        check(stabStatus, 5'h00, "stop clear");
        cyc(4);
        stopRelease = 1;
        cyc(1);
        stopRelease = 0;
        cyc(100);
        check(cpuRun, 0, "ran during wait");
        n = 0;
        while (cpuRun !== 1'b1 && n < 4000) begin
            cyc(1);
            n++;
        end
        check(n > 1900 && n < 2000, 1, "wait length");
        check(stabStatus, 5'h10, "status after stop");
    endtask
    // --------------------
    // run control
    // --------------------
    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        t_power;
        t_pins;
        t_main;
        t_xtal;
        t_stop;
        give_verdict;
    end
    // about three times the expected run length
    initial begin
        #200000;
        fails++;
        give_verdict;
    end
endmodule
